//--- hdl/mnpe_defines.svh
`ifndef MNPE_DEFINES_SVH
`define MNPE_DEFINES_SVH

// ****************************************
// opcode patterns
// ****************************************
`define MNPE_MUL_PREFIX 7'h01
`define MNPE_NEG_PREFIX 7'h36
`define MNPE_POP_WORD 16'h0006
`define MNPE_NOP_ZERO 16'h0000
`define MNPE_NOP_PREFIX 4'hF
`define MNPE_BANK_BIT 8

// ****************************************
// access bank split
// ****************************************
`define MNPE_ACCESS_SPLIT 8'h80
`define MNPE_ACCESS_LOW_BANK 4'h0
`define MNPE_ACCESS_HIGH_BANK 4'hF

// ****************************************
// status flag positions and resets
// ****************************************
`define MNPE_FLAG_C 0
`define MNPE_FLAG_DC 1
`define MNPE_FLAG_Z 2
`define MNPE_FLAG_OV 3
`define MNPE_FLAG_N 4
`define MNPE_FLAGS_RST 5'h00
`define MNPE_BYTE_RST 8'h00
`define MNPE_ADDR_RST 12'h000

`endif

//--- hdl/mnpe_pkg.sv
package mnpe_pkg;
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mnpe_phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_MUL, OP_NEG, OP_POP, OP_NOP} mnpe_op_t;
endpackage : mnpe_pkg

//--- hdl/mnpe_stack.sv
module mnpe_stack #(
	parameter int DEPTH = 31,
	parameter int WIDTH = 21,
	parameter int DEPTH_W = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] top,
	output logic [DEPTH_W-1:0] depth
);
	import mnpe_pkg::*;

	// ****************************************
	// top kept in its own flop, older entries below
	// ****************************************
	logic [WIDTH-1:0] below [DEPTH-1];
	logic [WIDTH-1:0] next_below [DEPTH-1];
	logic [WIDTH-1:0] next_top;
	logic [DEPTH_W-1:0] next_depth;

	always_comb begin
		next_below = below;
		next_top = top;
		next_depth = depth;
		// push on a full stack is dropped; pop on an empty one does nothing
		if (push && depth < DEPTH_W'(DEPTH)) begin
			if (depth != '0) begin
				next_below[depth - DEPTH_W'(1)] = top;
			end
			next_top = push_data;
			next_depth = depth + DEPTH_W'(1);
		end else if (pop && depth != '0) begin
			next_top = (depth > DEPTH_W'(1)) ? below[depth - DEPTH_W'(2)] : '0;
			next_depth = depth - DEPTH_W'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				below[i] <= '0;
			end
			top <= '0;
			depth <= '0;
		end else if (clk_en) begin
			below <= next_below;
			top <= next_top;
			depth <= next_depth;
		end
	end
endmodule : mnpe_stack

//--- hdl/mnpe_exec.sv
// Behaviour
// [RULE1] opcode 0000001a ffffffff multiplies working register by file register, unsigned.
// [RULE2] full 16-bit product goes to product_high (upper) and product_low (lower).
// [RULE3] multiply leaves working register and file register unchanged; only product written.
// [RULE4] multiply changes no status flag; zero product is not flagged.
// [RULE5] bank bit zero selects access bank; one uses bank_select_reg.
// [RULE6] opcode 0110110a ffffffff negates file register: inverted value plus one.
// [RULE7] negate writes back to same location, updating N, overflow, C, digit carry, Z.
// [RULE8] opcode 0x0006 pops the return stack top, flags untouched.
// [RULE9] after pop the previous entry becomes top; depth drops by one.
// [RULE10] all-zero word or upper nibble 1111 is no-operation changing nothing.
// [RULE11] each instruction is one word, one cycle: read, process, write in quarters.
`include "mnpe_defines.svh"

module mnpe_exec #(
	parameter int STACK_DEPTH = 31,
	parameter int PC_W = 21,
	parameter int DEPTH_W = $clog2(STACK_DEPTH + 1)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [7:0] w_reg,
	input wire logic [3:0] bank_select_reg,
	input wire logic [7:0] mem_rdata,
	input wire logic push_req,
	input wire logic [PC_W-1:0] push_data,
	output mnpe_pkg::mnpe_phase_t phase,
	output logic [11:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic [7:0] product_high,
	output logic [7:0] product_low,
	output logic [4:0] status_flags,
	output logic [PC_W-1:0] return_stack_top,
	output logic [DEPTH_W-1:0] stack_depth,
	output logic instr_done
);
	import mnpe_pkg::*;

	// ****************************************
	// state
	// ****************************************
	mnpe_phase_t next_phase;
	mnpe_op_t op, next_op;
	logic [11:0] next_mem_addr;
	logic next_mem_rd, next_mem_wr, next_instr_done;
	logic [7:0] next_mem_wdata, operand, next_operand, w_copy, next_w_copy;
	logic [15:0] product, next_product;
	logic [7:0] next_product_high, next_product_low;
	logic [4:0] flags_pend, next_flags_pend, next_status_flags;
	logic [8:0] neg_sum;
	logic [4:0] neg_low;
	logic stack_pop, stack_push;
	mnpe_op_t dec_op;
	logic [11:0] dec_addr;

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		dec_op = OP_NONE;
		if (instr[15:9] == `MNPE_MUL_PREFIX) begin
			dec_op = OP_MUL; // RULE1
		end else if (instr[15:9] == `MNPE_NEG_PREFIX) begin
			dec_op = OP_NEG; // RULE6
		end else if (instr == `MNPE_POP_WORD) begin
			dec_op = OP_POP; // RULE8
		end else if (instr == `MNPE_NOP_ZERO || instr[15:12] == `MNPE_NOP_PREFIX) begin
			dec_op = OP_NOP; // RULE10
		end
		// access bank keeps low ram and the special registers reachable without bank switching
		if (!instr[`MNPE_BANK_BIT]) begin
			dec_addr = {(instr[7:0] < `MNPE_ACCESS_SPLIT) ? `MNPE_ACCESS_LOW_BANK
				: `MNPE_ACCESS_HIGH_BANK, instr[7:0]}; // RULE5
		end else begin
			dec_addr = {bank_select_reg, instr[7:0]}; // RULE5
		end
	end

	// ****************************************
	// negate arithmetic
	// ****************************************
	always_comb begin
		neg_sum = {1'b0, ~operand} + 9'h001; // RULE6
		neg_low = {1'b0, ~operand[3:0]} + 5'h01;
	end

	// ****************************************
	// quarter phase sequence
	// ****************************************
	always_comb begin
		next_phase = phase;
		next_op = op;
		next_mem_addr = mem_addr;
		next_mem_rd = 1'b0;
		next_mem_wr = mem_wr;
		next_mem_wdata = mem_wdata;
		next_operand = operand;
		next_w_copy = w_copy;
		next_product = product;
		next_product_high = product_high;
		next_product_low = product_low;
		next_flags_pend = flags_pend;
		next_status_flags = status_flags;
		next_instr_done = 1'b0;
		unique case (phase)
			PH_Q1: begin
				next_phase = PH_Q2;
				next_op = instr_valid ? dec_op : OP_NONE;
				if (instr_valid && (dec_op == OP_MUL || dec_op == OP_NEG)) begin
					next_mem_addr = dec_addr;
					next_mem_rd = 1'b1; // RULE11
				end
			end
			PH_Q2: begin
				next_phase = PH_Q3;
				next_operand = mem_rdata;
				next_w_copy = w_reg;
			end
			PH_Q3: begin
				next_phase = PH_Q4;
				next_product = {8'h00, w_copy} * {8'h00, operand}; // RULE1
				if (op == OP_NEG) begin
					next_mem_wdata = neg_sum[7:0]; // RULE7
					next_mem_wr = 1'b1; // RULE7
					next_flags_pend[`MNPE_FLAG_C] = neg_sum[8];
					next_flags_pend[`MNPE_FLAG_DC] = neg_low[4];
					next_flags_pend[`MNPE_FLAG_Z] = (neg_sum[7:0] == 8'h00);
					next_flags_pend[`MNPE_FLAG_OV] = operand[7] & neg_sum[7];
					next_flags_pend[`MNPE_FLAG_N] = neg_sum[7];
				end
			end
			PH_Q4: begin
				next_phase = PH_Q1;
				next_mem_wr = 1'b0;
				next_instr_done = (op != OP_NONE); // RULE11
				if (op == OP_MUL) begin // RULE3
					next_product_high = product[15:8]; // RULE2
					next_product_low = product[7:0]; // RULE2
				end
				// multiply, pop and no-operation keep the flags
				if (op == OP_NEG) begin // RULE4
					next_status_flags = flags_pend; // RULE7
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase <= PH_Q1;
			op <= OP_NONE;
			mem_addr <= `MNPE_ADDR_RST;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= `MNPE_BYTE_RST;
			operand <= `MNPE_BYTE_RST;
			w_copy <= `MNPE_BYTE_RST;
			product <= 16'h0000;
			product_high <= `MNPE_BYTE_RST;
			product_low <= `MNPE_BYTE_RST;
			flags_pend <= `MNPE_FLAGS_RST;
			status_flags <= `MNPE_FLAGS_RST;
			instr_done <= 1'b0;
		end else if (clk_en) begin
			phase <= next_phase;
			op <= next_op;
			mem_addr <= next_mem_addr;
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			mem_wdata <= next_mem_wdata;
			operand <= next_operand;
			w_copy <= next_w_copy;
			product <= next_product;
			product_high <= next_product_high;
			product_low <= next_product_low;
			flags_pend <= next_flags_pend;
			status_flags <= next_status_flags;
			instr_done <= next_instr_done;
		end
	end

	// ****************************************
	// return stack
	// ****************************************
	// pushes are taken only in q2 so they never meet a pop, which acts in q3
	always_comb begin
		stack_push = push_req && phase == PH_Q2;
		stack_pop = (phase == PH_Q3) && (op == OP_POP); // RULE8
	end

	mnpe_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W),
		.DEPTH_W(DEPTH_W)
	) u_stack (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.push(stack_push),
		.push_data(push_data),
		.pop(stack_pop), // RULE9
		.top(return_stack_top),
		.depth(stack_depth)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (!resetn);

	a_mul_decode: assert property ( // RULE1
		(phase == PH_Q1 && instr_valid && instr[15:9] == `MNPE_MUL_PREFIX)
		|=> (op == OP_MUL && mem_rd))
		else $error("multiply not decoded");
	a_mul_product: assert property ( // RULE2
		(phase == PH_Q2 && op == OP_MUL)
		|-> ##3 ({product_high, product_low} == {8'h00, $past(w_reg, 3)} * {8'h00, $past(mem_rdata, 3)}))
		else $error("wrong product");
	a_mul_no_write: assert property ( // RULE3
		(op == OP_MUL) |-> !mem_wr)
		else $error("multiply wrote memory");
	a_mul_flags_kept: assert property ( // RULE4
		(phase == PH_Q4 && op == OP_MUL) |=> $stable(status_flags))
		else $error("multiply changed flags");
	a_access_bank: assert property ( // RULE5
		(phase == PH_Q1 && instr_valid && !instr[`MNPE_BANK_BIT] && instr[15:9] == `MNPE_NEG_PREFIX)
		|=> mem_addr[11:8] == ($past(instr[7]) ? `MNPE_ACCESS_HIGH_BANK : `MNPE_ACCESS_LOW_BANK))
		else $error("access bank not selected");
	a_neg_write: assert property ( // RULE6
		(phase == PH_Q2 && op == OP_NEG)
		|-> ##2 (mem_wr && mem_wdata == 8'(~$past(mem_rdata, 2) + 8'h01)
		&& $stable(mem_addr)))
		else $error("negate result wrong");
	a_neg_zero_flag: assert property ( // RULE7
		(phase == PH_Q2 && op == OP_NEG)
		|-> ##3 (status_flags[`MNPE_FLAG_Z] == ($past(mem_rdata, 3) == 8'h00)
		&& status_flags[`MNPE_FLAG_C] == ($past(mem_rdata, 3) == 8'h00)))
		else $error("negate flags wrong");
	a_pop_flags: assert property ( // RULE8
		(phase == PH_Q3 && op == OP_POP) |=> ##1 $stable(status_flags))
		else $error("pop changed flags");
	a_pop_depth: assert property ( // RULE9
		(phase == PH_Q3 && op == OP_POP && stack_depth != '0)
		|=> stack_depth == $past(stack_depth) - DEPTH_W'(1))
		else $error("pop did not drop depth");
	a_nop_quiet: assert property ( // RULE10
		(phase == PH_Q2 && op == OP_NOP)
		|-> (!mem_rd && !mem_wr) ##3 $stable(status_flags))
		else $error("no-operation had an effect");
	a_one_cycle: assert property ( // RULE11
		(phase == PH_Q1 && instr_valid && dec_op != OP_NONE)
		|-> ##4 (instr_done && phase == PH_Q1))
		else $error("instruction not done in one cycle");
endmodule : mnpe_exec

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mnpe_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic clk, resetn, clk_en, instr_valid, push_req;
	logic [15:0] instr;
	logic [7:0] w_reg, mem_rdata, mem_wdata, product_high, product_low;
	logic [3:0] bank_select_reg, bank;
	logic [20:0] push_data, return_stack_top;
	mnpe_phase_t phase;
	logic [11:0] mem_addr;
	logic mem_rd, mem_wr, instr_done;
	logic [4:0] status_flags, stack_depth, fl;
	logic rd_seen, wr_seen, done_seen;
	logic [11:0] addr_seen;
	logic [7:0] wdata_seen;
	int failures = 0;
	int n_compared = 0;
	// negate table: operand, result, flags {N,OV,Z,DC,C}
	logic [7:0] neg_in [3] = '{8'h3A, 8'h00, 8'h80};
	logic [7:0] neg_out [3] = '{8'hC6, 8'h00, 8'h80};
	logic [4:0] neg_fl [3] = '{5'h10, 5'h07, 5'h1A};

	mnpe_exec u_mnpe_exec (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr(instr), .w_reg(w_reg),
		.bank_select_reg(bank_select_reg), .mem_rdata(mem_rdata), .push_req(push_req),
		.push_data(push_data), .phase(phase), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .product_high(product_high),
		.product_low(product_low), .status_flags(status_flags),
		.return_stack_top(return_stack_top), .stack_depth(stack_depth),
		.instr_done(instr_done));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task print_verdict;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// one full instruction cycle; memory data only valid in Q2, inverted after
	task run(input logic [15:0] word, input logic [7:0] w, input logic [7:0] f,
		input logic psh, input logic [20:0] pd);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (phase !== PH_Q4 && i < 8);
		if (i >= 8) begin
			failures++;
			$display("ERROR t=%0t phase never reached Q4", $time);
			print_verdict();
		end
		@(posedge clk);
		instr <= word;
		bank_select_reg <= bank;
		instr_valid <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		w_reg <= w;
		mem_rdata <= f;
		push_req <= psh;
		push_data <= pd;
		#1;
		rd_seen = mem_rd;
		addr_seen = mem_addr;
		@(posedge clk);
		push_req <= 1'b0;
		w_reg <= ~w;
		mem_rdata <= ~f;
		#1;
		check(mem_rd, 1'b0, "read strobe too long");
		@(posedge clk);
		#1;
		wr_seen = mem_wr;
		wdata_seen = mem_wdata;
		@(posedge clk);
		#1;
		done_seen = instr_done;
		check(mem_wr, 1'b0, "write strobe too long");
	endtask : run

	// ****************************************
	// scenarios
	// ****************************************
	task t_neg;
		for (int k = 0; k < 3; k++) begin
			bank = 4'hA;
			run(k[0] ? 16'h6C90 : 16'h6D20, 8'h11, neg_in[k], 1'b0, 21'h0);
			check(addr_seen, k[0] ? 12'hF90 : 12'hA20, "neg address");
			check(rd_seen, 1'b1, "neg read");
			check(wr_seen, 1'b1, "neg write back");
			check(wdata_seen, neg_out[k], "neg result");
			check(status_flags, neg_fl[k], "neg flags");
			check(done_seen, 1'b1, "neg done");
		end
	endtask : t_neg

	task t_mul;
		fl = status_flags;
		bank = 4'h3;
		run(16'h0345, 8'hC4, 8'hB5, 1'b0, 21'h0);
		check(addr_seen, 12'h345, "mul banked address");
		check({product_high, product_low}, 16'h8A94, "mul product");
		check(wr_seen, 1'b0, "mul wrote memory");
		check(done_seen, 1'b1, "mul done");
		run(16'h02F0, 8'h00, 8'h77, 1'b0, 21'h0);
		check(addr_seen, 12'hFF0, "mul access high");
		check({product_high, product_low}, 16'h0000, "zero product");
		check(status_flags, fl, "mul touched flags");
		run(16'h0210, 8'hFF, 8'hFF, 1'b0, 21'h0);
		check(addr_seen, 12'h010, "mul access low");
		check(product_high, 8'hFE, "product high byte");
		check(product_low, 8'h01, "product low byte");
		check(status_flags, fl, "mul touched flags");
	endtask : t_mul

	task t_stack;
		fl = status_flags;
		run(16'h0000, 8'h00, 8'h00, 1'b1, 21'h0031A2);
		check(done_seen, 1'b1, "nop done");
		check({rd_seen, wr_seen}, 2'b00, "nop memory access");
		run(16'hF123, 8'h00, 8'h00, 1'b1, 21'h014332);
		check({product_high, product_low}, 16'hFE01, "nop product");
		check(status_flags, fl, "nop flags");
		check(stack_depth, 5'h02, "depth after pushes");
		run(16'h0006, 8'h00, 8'h00, 1'b0, 21'h0);
		check(return_stack_top, 21'h0031A2, "pop top");
		check(stack_depth, 5'h01, "pop depth");
		check(status_flags, fl, "pop flags");
		check(done_seen, 1'b1, "pop done");
		run(16'h0006, 8'h00, 8'h00, 1'b0, 21'h0);
		run(16'h0006, 8'h00, 8'h00, 1'b0, 21'h0);
		check(stack_depth, 5'h00, "pop on empty");
		run(16'h0007, 8'h00, 8'h00, 1'b0, 21'h0);
		check(done_seen, 1'b0, "unknown word done");
	endtask : t_stack

	// clock enable low must freeze phase and stack, even with a push pending
	task t_hold;
		mnpe_phase_t ph;
		logic [4:0] dep;
		@(posedge clk);
		clk_en <= 1'b0;
		push_req <= 1'b1;
		push_data <= 21'h0ABCDE;
		#1;
		ph = phase;
		dep = stack_depth;
		repeat (4) @(posedge clk);
		#1;
		check(phase, ph, "phase moved while frozen");
		check(stack_depth, dep, "stack moved while frozen");
		@(posedge clk);
		clk_en <= 1'b1;
		push_req <= 1'b0;
	endtask : t_hold

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		instr_valid = 1'b0;
		instr = 16'h0000;
		w_reg = 8'h00;
		bank_select_reg = 4'h0;
		bank = 4'h0;
		mem_rdata = 8'h00;
		push_req = 1'b0;
		push_data = 21'h0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		#1;
		check({product_high, product_low, status_flags}, 21'h0, "reset values");
		t_neg();
		t_mul();
		t_hold();
		t_stack();
		print_verdict();
	end
endmodule : testbench
